/* File: nrcc_host.sv */
`timescale 1ns/1ns
`default_nettype none
// Host model: plain register port master, strobes one cycle long
module nrcc_host
   import nrcc_pkg::*;
(
   // Clock
   input  wire logic  i_clk,
   // Register port
   output logic [3:0] o_addr,
   output logic [7:0] o_wdata,
   output logic       o_wr,
   output logic       o_rd
);
   logic [7:0] exp_q[$];
   logic [7:0] msk_q[$];
   // Idle bus from time zero
   initial begin
      o_addr = 4'h0;
      o_wdata = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // Write: strobe, address and data together for one edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
   endtask
   // Read: expected value noted for the monitor, masked bits ignored
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      exp_q.push_back(e);
      msk_q.push_back(m);
      @(posedge i_clk);
      o_rd <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: nrcc_pkg.sv */
package nrcc_pkg;
   // Register indices on the plain port (chosen map)
   localparam logic [3:0] ADDR_OP_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_IO_CFG2    = 4'h1;
   localparam logic [3:0] ADDR_RECEIVER_FILTER_CONFIG       = 4'h2;
   localparam logic [3:0] ADDR_REC2       = 4'h3;
   localparam logic [3:0] ADDR_REC3       = 4'h4;
   localparam logic [3:0] ADDR_REC4       = 4'h5;
   localparam logic [3:0] ADDR_MODE       = 4'h6;
   localparam logic [3:0] ADDR_COMMAND    = 4'h7;
   localparam logic [3:0] ADDR_GAIN_STATE = 4'h8;
   localparam logic [3:0] ADDR_STATUS     = 4'h9;
   localparam logic [3:0] ADDR_MASK_TIMER = 4'ha;

   // Operation control fields
   localparam int OP_RX_EN  = 6;
   localparam int OP_RX_CHN = 5;
   localparam int OP_RX_MAN = 4;
   localparam int OP_TX_EN  = 3;
   // IO config 2 fields
   localparam int IO2_SLOW_UP = 7;
   // Receiver config 1 fields
   localparam int RECEIVER_FILTER_CONFIG_AMD_SEL = 7;
   localparam int RECEIVER_FILTER_CONFIG_LP_LSB  = 3;
   localparam int RECEIVER_FILTER_CONFIG_Z_LSB   = 0;
   // Receiver config 2 fields
   localparam int REC2_LF_EN = 7;
   // Receiver config 3 fields
   localparam int REC3_BOOST = 0;
   localparam int REC3_G1_LSB = 5;

   // Reset values
   localparam logic [7:0] RST_OP_CTRL = 8'h00;
   localparam logic [7:0] RST_IO_CFG2 = 8'h00;
   localparam logic [7:0] RST_RECEIVER_FILTER_CONFIG    = 8'h00;
   localparam logic [7:0] RST_REC2    = 8'h00;
   localparam logic [7:0] RST_REC3    = 8'hc0;
   localparam logic [7:0] RST_REC4    = 8'h00;
   localparam logic [7:0] RST_MODE    = 8'h00;
   localparam logic [7:0] RST_TIMER   = 8'h10;

   // Direct command codes
   localparam logic [7:0] CMD_ANALOG_PRESET = 8'h01;
   localparam logic [7:0] CMD_MASK_RX       = 8'h02;
   localparam logic [7:0] CMD_UNMASK_RX     = 8'h03;
   localparam logic [7:0] CMD_RESET_RX_GAIN = 8'h04;
   localparam logic [7:0] CMD_START_MASK    = 8'h05;

   // Protocol modes for the preset
   localparam logic [2:0] MODE_NFCIP1   = 3'h0;
   localparam logic [2:0] MODE_A_128    = 3'h1;
   localparam logic [2:0] MODE_B_128    = 3'h2;
   localparam logic [2:0] MODE_FC8_FC4  = 3'h3;
   localparam logic [2:0] MODE_FC32_16  = 3'h4;
   localparam logic [2:0] MODE_STREAM   = 3'h5;
   localparam logic [2:0] MODE_TRANSP   = 3'h6;

   // Filter codes (low-pass, zero)
   localparam logic [2:0] LP_1200K = 3'b000;
   localparam logic [2:0] LP_2M    = 3'b100;
   localparam logic [2:0] LP_7M    = 3'b101;
   localparam logic [2:0] Z_60_400 = 3'b000;
   localparam logic [2:0] Z_60_200 = 3'b100;
   localparam logic [2:0] Z_40_80  = 3'b010;
   localparam logic [2:0] Z_12_200 = 3'b101;

   // Supply ramp timing
   localparam int CLK_MHZ       = 100;
   localparam int RAMP_TIME_NS  = 15000;
   localparam int RAMP_CYCLES   = RAMP_TIME_NS * CLK_MHZ / 1000;
   localparam int RAMP_STEPS    = 16;
   localparam int RAMP_STEP_CYC = RAMP_CYCLES / RAMP_STEPS;
   localparam int SLOW_MIN_US   = 2000;
   localparam int SLOW_MIN_CYC  = SLOW_MIN_US * CLK_MHZ;

   typedef enum logic [1:0] {
      NRCC_SUP_OFF  = 2'b00,
      NRCC_SUP_RAMP = 2'b01,
      NRCC_SUP_FULL = 2'b10
   } nrcc_sup_t;

   typedef struct packed {
      logic [7:0] addr_unused;
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } nrcc_bus_t;

   typedef struct packed {
      logic       rx_power;
      logic       both_channels;
      logic       manual_channel;
      logic       mixer_select;
      logic       lf_bypass;
      logic [2:0] lowpass_code;
      logic [2:0] zero_code;
      logic [2:0] stage1_reduce;
      logic       stage1_boost;
      logic [2:0] stage23_reduce;
   } nrcc_analog_t;
endpackage

/* File: nrcc_ramp.sv */
`timescale 1ns/1ns
`default_nettype none
// Stepped level generator for the driver supply
module nrcc_ramp #(
   parameter int STEP_CYC = 93,
   parameter int LEVEL_W  = 4
) (
   // Clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_nrst,
   input  wire logic               i_ce,
   // Control
   input  wire logic               i_collapse,
   input  wire logic               i_slow,
   input  wire logic               i_tx_en,
   // Level
   output logic [LEVEL_W-1:0]      o_level
);
   import nrcc_pkg::*;

   typedef struct packed {
      logic [LEVEL_W-1:0] level;
      logic [15:0]        cnt;
   } nrcc_ramp_st_t;

   localparam logic [LEVEL_W-1:0] FULL = '1;
   localparam logic [15:0] STEP_END = 16'(STEP_CYC - 1);

   nrcc_ramp_st_t st_reg;
   nrcc_ramp_st_t st_next;

   // Collapse when idle in slow mode, climb one step per interval
   always_comb begin
      st_next = st_reg;
      if (!i_tx_en && i_collapse) begin
         st_next.level = '0;
         st_next.cnt   = '0;
      end else if (!i_slow || !i_tx_en) begin
         st_next.level = FULL;
         st_next.cnt   = '0;
      end else if (st_reg.level != FULL) begin
         if (st_reg.cnt == STEP_END) begin
            st_next.cnt   = '0;
            st_next.level = st_reg.level + 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg <= '{level: '1, cnt: 16'h0000};
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   assign o_level = st_reg.level;
endmodule
`default_nettype wire

/* File: nrcc_top.sv */
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module nrcc_top #(
   parameter int TIMER_W = 8
) (
   // Clock, reset, enable
   input  wire logic                 i_clk,
   input  wire logic                 i_nrst,
   input  wire logic                 i_ce,
   // Register port
   input  wire logic [3:0]           i_addr,
   input  wire logic [7:0]           i_wdata,
   input  wire logic                 i_wr,
   input  wire logic                 i_rd,
   output logic [7:0]                o_rdata,
   // Events from the rest of the device
   input  wire logic                 i_tx_end,
   input  wire logic [2:0]           i_loop_reduce,
   input  wire logic                 i_loop_valid,
   input  wire logic                 i_squelch_step,
   // Analog control
   output nrcc_pkg::nrcc_analog_t    o_analog,
   output logic                      o_rx_window,
   output logic                      o_rssi_run,
   output logic                      o_agc_run,
   output logic                      o_framing_run,
   output logic [3:0]                o_rf_supply_level,
   output logic [2:0]                o_agc_shadow,
   output logic [2:0]                o_squelch_setting
);
   import nrcc_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [7:0]         op_ctrl;
      logic [7:0]         io_cfg2;
      logic [7:0]         receiver_filter_config;
      logic [7:0]         rec2;
      logic [7:0]         rec3;
      logic [7:0]         rec4;
      logic [7:0]         mode;
      logic [TIMER_W-1:0] timer_load;
      logic [TIMER_W-1:0] timer;
      logic               timer_run;
      logic               rx_on;
      logic [2:0]         shadow;
      logic [2:0]         squelch;
      logic [2:0]         gain_now;
      logic [7:0]         gain_state;
      logic [7:0]         rdata;
      nrcc_analog_t       analog;
      logic               rssi_run;
      logic               agc_run;
      logic               framing_run;
      logic [3:0]         supply;
   } nrcc_st_t;

   nrcc_st_t   st_reg;
   nrcc_st_t   st_next;
   logic [3:0] ramp_level;
   logic [2:0] sum_red;

   localparam logic [2:0] GAIN_MAX_RED = 3'h6;

   ////////////////////////////////////////////////////////////////////////
   // Driver supply ramp; host owns the 2 ms discharge hold
   nrcc_ramp #(
      .STEP_CYC (RAMP_STEP_CYC),
      .LEVEL_W  (4)
   ) u_ramp (
      .i_clk      (i_clk),
      .i_nrst     (i_nrst),
      .i_ce       (i_ce),
      .i_collapse (st_reg.io_cfg2[IO2_SLOW_UP]),
      .i_slow     (st_reg.io_cfg2[IO2_SLOW_UP]),
      .i_tx_en    (st_reg.op_ctrl[OP_TX_EN]),
      .o_level    (ramp_level)
   );

   // Saturating squelch plus shadow, capped at six steps
   always_comb begin
      if ({1'b0, st_reg.shadow} + {1'b0, st_reg.squelch} > {1'b0, GAIN_MAX_RED}) begin
         sum_red = GAIN_MAX_RED;
      end else begin
         sum_red = 3'(st_reg.shadow + st_reg.squelch);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      st_next = st_reg;
      st_next.rdata = 8'h00;
      // Register writes and direct commands
      if (i_wr) begin
         if (i_addr == ADDR_OP_CTRL) begin
            st_next.op_ctrl = i_wdata;
         end else if (i_addr == ADDR_IO_CFG2) begin
            st_next.io_cfg2 = i_wdata;
         end else if (i_addr == ADDR_RECEIVER_FILTER_CONFIG) begin
            st_next.receiver_filter_config = i_wdata;
         end else if (i_addr == ADDR_REC2) begin
            st_next.rec2 = i_wdata;
         end else if (i_addr == ADDR_REC3) begin
            st_next.rec3 = i_wdata;
         end else if (i_addr == ADDR_REC4) begin
            st_next.rec4 = i_wdata;
         end else if (i_addr == ADDR_MODE) begin
            st_next.mode = i_wdata;
         end else if (i_addr == ADDR_MASK_TIMER) begin
            st_next.timer_load = i_wdata[TIMER_W-1:0];
         end else if (i_addr == ADDR_COMMAND) begin
            if (i_wdata == CMD_MASK_RX) begin
               st_next.rx_on     = 1'b0;
               st_next.timer_run = 1'b0;
            end else if (i_wdata == CMD_UNMASK_RX) begin
               st_next.rx_on     = 1'b1;
               st_next.timer_run = 1'b0;
            end else if (i_wdata == CMD_START_MASK) begin
               st_next.timer     = st_reg.timer_load;
               st_next.timer_run = 1'b1;
               st_next.rx_on     = 1'b0;
            end else if (i_wdata == CMD_RESET_RX_GAIN) begin
               st_next.squelch = 3'h0;
               st_next.shadow  = st_reg.rec4[2:0];
            end else if (i_wdata == CMD_ANALOG_PRESET) begin
               // Stream and transparent keep host filter settings
               case (st_reg.mode[2:0])
                  MODE_NFCIP1: begin
                     st_next.receiver_filter_config[5:0]          = {LP_1200K, Z_12_200};
                     st_next.receiver_filter_config[RECEIVER_FILTER_CONFIG_AMD_SEL] = 1'b0;
                  end
                  MODE_A_128: begin
                     st_next.receiver_filter_config[5:0]          = {LP_1200K, Z_60_400};
                     st_next.receiver_filter_config[RECEIVER_FILTER_CONFIG_AMD_SEL] = 1'b0;
                  end
                  MODE_B_128: begin
                     st_next.receiver_filter_config[5:0]          = {LP_1200K, Z_60_200};
                     st_next.receiver_filter_config[RECEIVER_FILTER_CONFIG_AMD_SEL] = 1'b0;
                  end
                  MODE_FC32_16: begin
                     st_next.receiver_filter_config[5:0]          = {LP_2M, Z_40_80};
                     st_next.receiver_filter_config[RECEIVER_FILTER_CONFIG_AMD_SEL] = 1'b0;
                  end
                  MODE_FC8_FC4: begin
                     st_next.receiver_filter_config[5:0]          = {LP_7M, Z_60_200};
                     st_next.receiver_filter_config[RECEIVER_FILTER_CONFIG_AMD_SEL] = 1'b1;
                  end
                  default: begin
                     st_next.receiver_filter_config = st_reg.receiver_filter_config;
                  end
               endcase
            end
         end
      end
      // Mask timer; expiry raises the window
      if (st_reg.timer_run && !(i_wr && i_addr == ADDR_COMMAND)) begin
         if (st_reg.timer == '0) begin
            st_next.timer_run = 1'b0;
            st_next.rx_on     = 1'b1;
         end else begin
            st_next.timer = st_reg.timer - 1'b1;
         end
      end
      if (i_tx_end && !st_reg.timer_run) begin
         st_next.timer     = st_reg.timer_load;
         st_next.timer_run = 1'b1;
      end
      // Loops step gain only inside a window
      if (st_reg.rx_on && i_squelch_step && st_reg.squelch != GAIN_MAX_RED
          && !(i_wr && i_addr == ADDR_COMMAND && i_wdata == CMD_RESET_RX_GAIN)) begin
         st_next.squelch = st_reg.squelch + 3'h1;
      end
      if (st_reg.rx_on && i_loop_valid) begin
         st_next.gain_now = (i_loop_reduce > GAIN_MAX_RED) ? GAIN_MAX_RED : i_loop_reduce;
      end else if (!st_reg.rx_on) begin
         st_next.gain_now = sum_red;
      end
      // Window falling edge captures gain
      if (st_reg.rx_on && !st_next.rx_on) begin
         st_next.gain_state = {5'h00, st_reg.gain_now};
      end
      // Decoded analog controls
      st_next.analog.rx_power       = st_next.op_ctrl[OP_RX_EN];
      st_next.analog.both_channels  = st_next.op_ctrl[OP_RX_CHN];
      st_next.analog.manual_channel = st_next.op_ctrl[OP_RX_MAN];
      st_next.analog.mixer_select   = st_next.receiver_filter_config[RECEIVER_FILTER_CONFIG_AMD_SEL];
      st_next.analog.lf_bypass      = st_next.rec2[REC2_LF_EN];
      st_next.analog.lowpass_code   = st_next.receiver_filter_config[RECEIVER_FILTER_CONFIG_LP_LSB+:3];
      st_next.analog.zero_code      = st_next.receiver_filter_config[RECEIVER_FILTER_CONFIG_Z_LSB+:3];
      st_next.analog.stage1_reduce  = (st_next.rec3[REC3_G1_LSB+:3] > GAIN_MAX_RED) ?
                                      GAIN_MAX_RED : st_next.rec3[REC3_G1_LSB+:3];
      st_next.analog.stage1_boost   = st_next.rec3[REC3_BOOST];
      st_next.analog.stage23_reduce = st_next.rx_on ? st_next.gain_now : sum_red;
      // Processing gated by window and receiver power
      st_next.rssi_run    = st_next.rx_on && st_next.op_ctrl[OP_RX_EN];
      st_next.agc_run     = st_next.rx_on && st_next.op_ctrl[OP_RX_EN];
      st_next.framing_run = st_next.rx_on && st_next.op_ctrl[OP_RX_EN];
      st_next.supply      = ramp_level;
      // Register reads, data valid in the next cycle
      if (i_rd) begin
         if (i_addr == ADDR_OP_CTRL) begin
            st_next.rdata = st_reg.op_ctrl;
         end else if (i_addr == ADDR_IO_CFG2) begin
            st_next.rdata = st_reg.io_cfg2;
         end else if (i_addr == ADDR_RECEIVER_FILTER_CONFIG) begin
            st_next.rdata = st_reg.receiver_filter_config;
         end else if (i_addr == ADDR_REC2) begin
            st_next.rdata = st_reg.rec2;
         end else if (i_addr == ADDR_REC3) begin
            st_next.rdata = st_reg.rec3;
         end else if (i_addr == ADDR_REC4) begin
            st_next.rdata = st_reg.rec4;
         end else if (i_addr == ADDR_MODE) begin
            st_next.rdata = st_reg.mode;
         end else if (i_addr == ADDR_GAIN_STATE) begin
            st_next.rdata = st_reg.gain_state;
         end else if (i_addr == ADDR_STATUS) begin
            st_next.rdata = {st_reg.rx_on, st_reg.timer_run, 2'b00, st_reg.supply};
         end else if (i_addr == ADDR_MASK_TIMER) begin
            st_next.rdata = 8'(st_reg.timer_load);
         end else begin
            st_next.rdata = 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         st_reg            <= '0;
         st_reg.rec3       <= RST_REC3;
         st_reg.timer_load <= TIMER_W'(RST_TIMER);
         st_reg.supply     <= 4'hf;
         st_reg.analog.stage1_reduce <= GAIN_MAX_RED;
      end else if (i_ce) begin
         st_reg <= st_next;
      end
   end

   assign o_rdata           = st_reg.rdata;
   assign o_analog          = st_reg.analog;
   assign o_rx_window       = st_reg.rx_on;
   assign o_rssi_run        = st_reg.rssi_run;
   assign o_agc_run         = st_reg.agc_run;
   assign o_framing_run     = st_reg.framing_run;
   assign o_rf_supply_level = st_reg.supply;
   assign o_agc_shadow      = st_reg.shadow;
   assign o_squelch_setting = st_reg.squelch;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_fall;
      st_reg.rx_on ##1 !st_reg.rx_on;
   endsequence

   a_rx_power: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce ##1 1'b1 |-> o_analog.rx_power == $past(st_next.op_ctrl[OP_RX_EN]))
      else $error("receiver power does not follow enable");
   a_window_gate: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !o_rx_window |-> !o_agc_run && !o_rssi_run && !o_framing_run)
      else $error("processing active outside window");
   a_mask_cmd: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == ADDR_COMMAND && i_wdata == CMD_MASK_RX |=> !o_rx_window)
      else $error("mask command did not lower window");
   a_unmask_cmd: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == ADDR_COMMAND && i_wdata == CMD_UNMASK_RX |=> o_rx_window)
      else $error("unmask command did not raise window");
   a_gain_latch: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_fall |-> st_reg.gain_state[2:0] == $past(st_reg.gain_now))
      else $error("gain state not latched at window fall");
   a_gain_reset: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == ADDR_COMMAND && i_wdata == CMD_RESET_RX_GAIN
      |=> o_squelch_setting == 3'h0 && o_agc_shadow == $past(st_reg.rec4[2:0]))
      else $error("reset gain command mishandled");
   a_preset_fast: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && i_wr && i_addr == ADDR_COMMAND && i_wdata == CMD_ANALOG_PRESET
      && st_reg.mode[2:0] == MODE_FC8_FC4 |=> st_reg.receiver_filter_config[7:0] == {1'b1, st_reg.receiver_filter_config[6], 6'b101100})
      else $error("fast rate preset wrong");
   a_stage1_cap: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_analog.stage1_reduce <= GAIN_MAX_RED)
      else $error("first stage reduction beyond six steps");
   a_slow_collapse: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_ce && st_reg.io_cfg2[IO2_SLOW_UP] && !st_reg.op_ctrl[OP_TX_EN] ##1 i_ce
      |=> o_rf_supply_level == 4'h0)
      else $error("supply not collapsed");
endmodule
`default_nettype wire

/* File: nrcc_top_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module nrcc_top_tb_top;
   import nrcc_pkg::*;
   logic         clk, nrst, ce, tx_end, lp_valid, sq_step, bwr, brd, rd_d;
   logic [2:0]   lp_red, shadow, squelch, gx;
   logic [3:0]   addr, sup;
   logic [7:0]   wdata, rdata, v, e, m;
   logic         win, rssi, agc, frm;
   nrcc_analog_t an;
   int           failures, num_checks, seed, k;
   logic [2:0]   pm[5] = '{MODE_NFCIP1, MODE_A_128, MODE_FC8_FC4, MODE_STREAM, MODE_TRANSP};
   logic [7:0]   pe[5] = '{8'h05, 8'h00, 8'hac, 8'h1b, 8'h1b};
   logic [7:0]   pk[5] = '{8'h3f, 8'h3f, 8'hbf, 8'hff, 8'hff};

   initial clk = 1'b0;
   always #5 clk = ~clk;

   nrcc_host host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(bwr), .o_rd(brd));
   // Clock enable driven so one write can be frozen out
   nrcc_top uut (.i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_addr(addr), .i_wdata(wdata),
      .i_wr(bwr), .i_rd(brd), .o_rdata(rdata), .i_tx_end(tx_end), .i_loop_reduce(lp_red),
      .i_loop_valid(lp_valid), .i_squelch_step(sq_step), .o_analog(an), .o_rx_window(win),
      .o_rssi_run(rssi), .o_agc_run(agc), .o_framing_run(frm), .o_rf_supply_level(sup),
      .o_agc_shadow(shadow), .o_squelch_setting(squelch));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] g, input logic [7:0] x, input string s);
      num_checks++;
      if (g !== x) begin
         failures++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, x);
      end
   endtask
   task automatic results;
      if (failures == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [3:0] probe(input bit w);
      return w ? sup : {3'h0, win};
   endfunction
   // Bounded wait so a stuck output fails instead of hanging
   task automatic wait_for(input bit w, input logic [3:0] x, input int lim);
      int n;
      n = 0;
      while (probe(w) !== x && n < lim) begin
         step(1);
         n++;
      end
      chk(8'(probe(w)), 8'(x), "wait");
   endtask
   task automatic pulse(input int w);
      @(posedge clk);
      if (w == 0) tx_end <= 1'b1;
      else if (w == 1) sq_step <= 1'b1;
      lp_valid <= (w == 2);
      lp_red <= 3'($random(seed));
      @(posedge clk);
      {tx_end, sq_step, lp_valid} <= 3'h0;
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_d) begin
         e = host.exp_q.pop_front();
         m = host.msk_q.pop_front();
         chk(rdata & m, e & m, "read");
      end
      rd_d <= brd;
   end
   // Watchdog, far beyond the expected run
   initial begin
      #400000;
      failures++;
      results;
   end
   initial begin
      {seed, failures, num_checks} = {32'd80, 32'd0, 32'd0};
      {nrst, tx_end, lp_valid, sq_step, lp_red} = 7'h00;
      ce = 1'b1;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      step(1);
      chk(8'(an.stage1_reduce), 8'h06, "min gain");
      chk(8'(an.rx_power), 8'h00, "rx off");
      host.rd(ADDR_REC3, RST_REC3, 8'hff);
      host.rd(ADDR_RECEIVER_FILTER_CONFIG, RST_RECEIVER_FILTER_CONFIG, 8'hff);
      host.rd(4'hf, 8'h00, 8'hff);
      // Random filter codes 0 to 5 decode straight to the analog side
      for (k = 0; k < 6; k++) begin
         v = 8'($random(seed));
         v[2:0] = v[2:0] % 3'd6;
         v[5:3] = v[5:3] % 3'd6;
         host.wr(ADDR_RECEIVER_FILTER_CONFIG, v);
         step(1);
         chk(8'(an.zero_code), 8'(v[2:0]), "zero");
         chk(8'(an.lowpass_code), 8'(v[5:3]), "lowpass");
         chk(8'(an.mixer_select), 8'(v[7]), "demod");
         host.rd(ADDR_RECEIVER_FILTER_CONFIG, v, 8'hff);
      end
      host.wr(ADDR_REC3, 8'h41);
      host.wr(ADDR_REC2, 8'h80);
      host.wr(ADDR_OP_CTRL, 8'h70);
      step(1);
      chk(8'(an.stage1_reduce), 8'h02, "stage1");
      chk(8'(an.stage1_boost), 8'h01, "boost");
      chk(8'(an.lf_bypass), 8'h01, "bypass");
      chk({5'h0, an.rx_power, an.both_channels, an.manual_channel}, 8'h07, "chan");
      host.wr(ADDR_OP_CTRL, 8'h40);
      step(1);
      chk({5'h0, an.rx_power, an.both_channels, an.manual_channel}, 8'h04, "chan");
      // Enable low: a write must leave the bypass bit untouched
      @(posedge clk) ce <= 1'b0;
      host.wr(ADDR_REC2, 8'h00);
      ce <= 1'b1;
      step(1);
      chk(8'(an.lf_bypass), 8'h01, "frozen");
      // Presets per mode; stream and transparent leave the filters alone
      for (k = 0; k < 5; k++) begin
         host.wr(ADDR_RECEIVER_FILTER_CONFIG, 8'h1b);
         host.wr(ADDR_MODE, {5'h0, pm[k]});
         host.wr(ADDR_COMMAND, CMD_ANALOG_PRESET);
         host.rd(ADDR_RECEIVER_FILTER_CONFIG, pe[k], pk[k]);
      end
      host.wr(ADDR_COMMAND, CMD_UNMASK_RX);
      wait_for(0, 4'h1, 10);
      step(1);
      chk({5'h0, rssi, agc, frm}, 8'h07, "gated on");
      pulse(2);
      gx = (lp_red > 3'h6) ? 3'h6 : lp_red;
      pulse(1);
      step(1);
      chk(8'(squelch), 8'h01, "squelch");
      chk(8'(an.stage23_reduce), 8'(gx), "loop gain");
      host.wr(ADDR_REC4, 8'h03);
      host.wr(ADDR_COMMAND, CMD_RESET_RX_GAIN);
      step(1);
      chk({2'h0, shadow, squelch}, 8'h18, "reset gain");
      host.wr(ADDR_COMMAND, CMD_MASK_RX);
      wait_for(0, 4'h0, 10);
      step(1);
      chk({5'h0, rssi, agc, frm}, 8'h00, "gated off");
      host.rd(ADDR_GAIN_STATE, {5'h0, gx}, 8'hff);
      host.wr(ADDR_MASK_TIMER, 8'h04);
      pulse(0);
      step(2);
      chk(8'(win), 8'h00, "timer early");
      wait_for(0, 4'h1, 20);
      host.wr(ADDR_COMMAND, CMD_MASK_RX);
      // Slow ramp; the off hold is cut to the collapse itself to bound the run
      host.wr(ADDR_OP_CTRL, 8'h00);
      host.wr(ADDR_IO_CFG2, 8'h80);
      wait_for(1, 4'h0, 3000);
      host.wr(ADDR_OP_CTRL, 8'h08);
      step(20);
      chk(8'(sup == 4'hf), 8'h00, "gradual");
      wait_for(1, 4'hf, 3000);
      host.wr(ADDR_IO_CFG2, 8'h00);
      step(3);
      results;
   end
endmodule
`default_nettype wire
